// ### verilog/tic_defs.svh
// offsets, field positions and reset values of the trap and interrupt control
// assumes inclusion by bare name from the design files
`ifndef TIC_DEFS_SVH
`define TIC_DEFS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TIC_OFF_TRAP_CTL 4'h0
`define TIC_OFF_VEC_EDGE 4'h4
`define TIC_OFF_IRQ_STAT 4'h8
`define TIC_OFF_IRQ_MASK 4'hC
// ----------------------------------------
// trap control and status fields
// ----------------------------------------
`define TIC_NEST_DIS_BIT 15
`define TIC_OVA_FLAG_BIT 14
`define TIC_OVB_FLAG_BIT 13
`define TIC_COVA_FLAG_BIT 12
`define TIC_COVB_FLAG_BIT 11
`define TIC_OVA_TE_BIT 10
`define TIC_OVB_TE_BIT 9
`define TIC_COV_TE_BIT 8
`define TIC_SHIFT_FAULT_BIT 7
`define TIC_DIV_FAULT_BIT 6
`define TIC_ARITH_FAULT_BIT 4
`define TIC_ADDR_FAULT_BIT 3
`define TIC_STACK_FAULT_BIT 2
`define TIC_CLK_FAIL_BIT 1
// writable mask of the first control register, bits 5 and 0 unimplemented
`define TIC_TRAP_CTL_WMASK 16'hFFDE
// ----------------------------------------
// vector and edge control fields
// ----------------------------------------
`define TIC_ALT_VEC_BIT 15
`define TIC_IRQ_DIS_BIT 14
`define TIC_EDGE_LSB 0
`define TIC_VEC_EDGE_WMASK 16'h8007
// ----------------------------------------
// reset values
// ----------------------------------------
`define TIC_TRAP_CTL_RST 16'h0000
`define TIC_VEC_EDGE_RST 16'h0000
`define TIC_IRQ_MASK_RST 16'h0000
`endif

// ### verilog/tic_pkg.sv
// types shared by the trap and interrupt control files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package tic_pkg;
  typedef logic [15:0] tic_word_t; // one register word
  typedef enum logic [1:0] {
    TIC_BUS_IDLE = 2'b00,
    TIC_BUS_ACK = 2'b01
  } tic_bus_e;
endpackage
`default_nettype wire

// ### verilog/tic_edge_det.sv
// one external interrupt input: synchroniser and selectable edge detector
// assumes the pin is asynchronous to sys_clk_i
`timescale 1ns/10ps
`default_nettype none
module tic_edge_det (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic pin_i, // raw external pin
  input wire logic falling_i, // 1 selects falling edge
  output logic edge_o // one-cycle request pulse
);
  logic meta_ff; // first stage, read only by sync_ff
  logic sync_ff; // second stage
  logic prev_ff; // previous synchronised level

  // two-stage synchroniser then a history flop
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else if (clk_en_i) begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // polarity picks which transition counts
  assign edge_o = clk_en_i & (falling_i ? (prev_ff & ~sync_ff) : (~prev_ff & sync_ff)); // [RL9]
endmodule // tic_edge_det
`default_nettype wire

// ### verilog/tic_trap_ctl.sv
// trap and interrupt control: trap enables, sticky trap flags, vector table select,
// interrupt-disable status and edge selection of three external interrupt inputs
// assumes an Avalon-MM master on sys_clk_i and trap events as one-cycle pulses from the core
// assumes clk_en_i comes from logic on sys_clk_i and needs no synchroniser
// limitation: only the low half of the data bus carries register bits
//
// Summary of operation
// [RL1] overflow traps raised only when their enable set
// [RL2] catastrophic overflow trap only when enabled
// [RL3] divide fault set on divide-by-zero arithmetic trap
// [RL4] address fault flag set on address trap
// [RL5] stack fault flag set on stack trap
// [RL6] clock failure flag set on oscillator trap
// [RL7] unimplemented bits read zero, ignore writes
// [RL8] vector select: 1 alternate, 0 standard
// [RL9] edge polarity: 1 falling, 0 rising
// [RL10] input 0 polarity resets to rising
// [RL11] flags sticky until written zero; disable bit read-only
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`include "tic_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tic_trap_ctl (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i, // freezes all state while low
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // trap events from the core, one-cycle pulses
  input wire logic acc_a_ovf_i,
  input wire logic acc_b_ovf_i,
  input wire logic acc_a_cat_ovf_i,
  input wire logic acc_b_cat_ovf_i,
  input wire logic shift_acc_fault_i,
  input wire logic arith_trap_i,
  input wire logic arith_div0_i, // qualifies arith_trap_i
  input wire logic address_trap_i,
  input wire logic stack_trap_i,
  input wire logic osc_fail_trap_i,
  input wire logic irq_disable_instr_active_i, // level from the core instruction counter
  // external interrupt pins
  input wire logic [2:0] ext_irq_pin_i,
  // outputs to the core
  output logic acc_trap_o, // accumulator trap request pulse
  output logic vector_table_select_o,
  output logic nest_disable_o,
  output logic [2:0] ext_irq_req_o, // edge request pulses
  output logic irq_o // level interrupt
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  tic_pkg::tic_word_t trap_ctl_ff; // first control register
  tic_pkg::tic_word_t vec_edge_ff; // second control register, writable bits
  tic_pkg::tic_word_t irq_stat_ff; // sticky event bits
  tic_pkg::tic_word_t irq_mask_ff; // interrupt enables
  logic idis_meta_ff; // first sync stage
  logic idis_sync_ff; // second sync stage
  tic_pkg::tic_bus_e bus_ff; // bus answer state
  logic [31:0] rdata_ff; // registered read data
  logic acc_trap_ff; // registered trap request

  // helper terms, all combinational
  logic bus_req; // a request is pending
  logic wr_take; // write is completed this cycle
  logic [15:0] be_mask; // byte enables expanded to bits
  logic [15:0] wdata; // low half of write data
  logic ova_hit, ovb_hit, cova_hit, covb_hit; // enabled overflow events
  logic [15:0] trap_set; // hardware set bits of the first register
  logic [15:0] ev_set; // event set bits of interrupt status
  logic [2:0] edge_hit; // edge detector outputs
  logic [15:0] vec_edge_rd; // read view of the second register

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // read and write are never high together, so either one is a request
  assign bus_req = avs_read_i | avs_write_i;
  // every access waits one cycle; answer released on the second edge
  // trade-off: one fixed wait state keeps read data registered at little cost
  assign avs_waitrequest_o = bus_req & (bus_ff != tic_pkg::TIC_BUS_ACK);
  // a write lands only at the edge where waitrequest is seen low
  assign wr_take = avs_write_i & (bus_ff == tic_pkg::TIC_BUS_ACK) & clk_en_i;
  // byte lanes above the low half are ignored
  assign be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wdata = avs_writedata_i[15:0] & be_mask;

  // two-state answer machine: idle, then ack for one cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_ff <= tic_pkg::TIC_BUS_IDLE;
    end else if (clk_en_i) begin
      unique case (bus_ff)
        tic_pkg::TIC_BUS_IDLE: begin
          if (bus_req) begin
            bus_ff <= tic_pkg::TIC_BUS_ACK;
          end
        end
        tic_pkg::TIC_BUS_ACK: begin
          bus_ff <= tic_pkg::TIC_BUS_IDLE;
        end
        default: begin
          bus_ff <= tic_pkg::TIC_BUS_IDLE; // unused code recovers
        end
      endcase
    end
  end

  // ----------------------------------------
  // trap qualification
  // ----------------------------------------
  // a disabled overflow neither traps nor raises its flag
  // catastrophic overflow of either accumulator shares one enable
  assign ova_hit = acc_a_ovf_i & trap_ctl_ff[`TIC_OVA_TE_BIT]; // [RL1]
  assign ovb_hit = acc_b_ovf_i & trap_ctl_ff[`TIC_OVB_TE_BIT]; // [RL1]
  assign cova_hit = acc_a_cat_ovf_i & trap_ctl_ff[`TIC_COV_TE_BIT]; // [RL2]
  assign covb_hit = acc_b_cat_ovf_i & trap_ctl_ff[`TIC_COV_TE_BIT]; // [RL2]

  // collect hardware set terms in register layout
  // hazard: the divide qualifier alone means nothing outside an arithmetic trap
  // shift accumulator faults are logged but never gated
  always_comb begin
    trap_set = 16'h0000;
    trap_set[`TIC_OVA_FLAG_BIT] = ova_hit;
    trap_set[`TIC_OVB_FLAG_BIT] = ovb_hit;
    trap_set[`TIC_COVA_FLAG_BIT] = cova_hit;
    trap_set[`TIC_COVB_FLAG_BIT] = covb_hit;
    trap_set[`TIC_SHIFT_FAULT_BIT] = shift_acc_fault_i;
    trap_set[`TIC_DIV_FAULT_BIT] = arith_trap_i & arith_div0_i; // [RL3]
    trap_set[`TIC_ARITH_FAULT_BIT] = arith_trap_i;
    trap_set[`TIC_ADDR_FAULT_BIT] = address_trap_i; // [RL4]
    trap_set[`TIC_STACK_FAULT_BIT] = stack_trap_i; // [RL5]
    trap_set[`TIC_CLK_FAIL_BIT] = osc_fail_trap_i; // [RL6]
  end

  // first control register: software write, hardware set wins over clear
  // hazard: a zero written with a trap in one cycle must not lose it, so set comes last
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trap_ctl_ff <= `TIC_TRAP_CTL_RST;
    end else if (clk_en_i) begin
      if (wr_take && avs_address_i == `TIC_OFF_TRAP_CTL) begin
        // unimplemented bits never stored; a zero write clears a flag
        trap_ctl_ff <= (((trap_ctl_ff & ~be_mask) | wdata) | trap_set)
                       & `TIC_TRAP_CTL_WMASK; // [RL7] [RL11]
      end else begin
        trap_ctl_ff <= (trap_ctl_ff | trap_set) & `TIC_TRAP_CTL_WMASK; // [RL11]
      end
    end
  end

  // accumulator trap request to the core, one cycle after the event
  // the request is frozen with the rest of the state while clk_en_i is low
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_trap_ff <= 1'b0;
    end else if (clk_en_i) begin
      acc_trap_ff <= ova_hit | ovb_hit | cova_hit | covb_hit; // [RL1] [RL2]
    end
  end

  // ----------------------------------------
  // vector and edge control
  // ----------------------------------------
  // polarity bits reset to rising edge; only writable bits stored
  // the status bit is never stored here; it is merged into the read view
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_edge_ff <= `TIC_VEC_EDGE_RST; // [RL10]
    end else if (clk_en_i && wr_take && avs_address_i == `TIC_OFF_VEC_EDGE) begin
      vec_edge_ff <= ((vec_edge_ff & ~be_mask) | wdata) & `TIC_VEC_EDGE_WMASK; // [RL7]
    end
  end

  // interrupt-disable status comes from another unit; synchronised for safety
  // the two stages cost two cycles of latency on the status bit
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idis_meta_ff <= 1'b0;
      idis_sync_ff <= 1'b0;
    end else if (clk_en_i) begin
      idis_meta_ff <= irq_disable_instr_active_i;
      idis_sync_ff <= idis_meta_ff;
    end
  end

  // read view: status bit is hardware owned and cannot be written
  always_comb begin
    vec_edge_rd = vec_edge_ff;
    vec_edge_rd[`TIC_IRQ_DIS_BIT] = idis_sync_ff; // [RL11]
  end

  // three edge detectors, one per external input
  // each input has its own polarity bit in bits 2:0
  // the detectors share clock, reset and enable with this module
  genvar gi;
  for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
    tic_edge_det u_edge (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clk_en_i(clk_en_i),
      .pin_i(ext_irq_pin_i[gi]),
      .falling_i(vec_edge_ff[`TIC_EDGE_LSB + gi]), // [RL9]
      .edge_o(edge_hit[gi])
    );
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  // status layout mirrors bits 15:3 of the first register; edge requests take bits 2:0, so no stack or clock failure bit
  assign ev_set = {trap_set[15:3], edge_hit};

  // sticky status, write one to clear, new event wins
  // edge events have no bit of their own elsewhere, so they take bits 2:0
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_ff <= 16'h0000;
    end else if (clk_en_i) begin
      if (wr_take && avs_address_i == `TIC_OFF_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~wdata) | ev_set;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev_set;
      end
    end
  end

  // mask register
  // byte enables apply as in the control registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_ff <= `TIC_IRQ_MASK_RST;
    end else if (clk_en_i && wr_take && avs_address_i == `TIC_OFF_IRQ_MASK) begin
      irq_mask_ff <= (irq_mask_ff & ~be_mask) | wdata;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // unmapped addresses read zero; upper half always zero
  // captured at the first edge of an access so it stands at the second
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (clk_en_i && avs_read_i && bus_ff == tic_pkg::TIC_BUS_IDLE) begin
      unique case (avs_address_i)
        `TIC_OFF_TRAP_CTL: rdata_ff <= {16'h0000, trap_ctl_ff}; // [RL7]
        `TIC_OFF_VEC_EDGE: rdata_ff <= {16'h0000, vec_edge_rd}; // [RL7]
        `TIC_OFF_IRQ_STAT: rdata_ff <= {16'h0000, irq_stat_ff};
        `TIC_OFF_IRQ_MASK: rdata_ff <= {16'h0000, irq_mask_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_readdata_o = rdata_ff;
  assign acc_trap_o = acc_trap_ff;
  assign vector_table_select_o = vec_edge_ff[`TIC_ALT_VEC_BIT]; // [RL8]
  // nesting disable is a plain stored bit passed to the core
  assign nest_disable_o = trap_ctl_ff[`TIC_NEST_DIS_BIT];
  assign ext_irq_req_o = edge_hit;
  // the interrupt output is a level; it drops only when software clears or masks
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // each label line except that of a_stat_sticky ends with the rule that the check guards
  // every check is disabled in reset so no value from reset leaks into a past
  a_ovb_trap_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL1]
    (clk_en_i && acc_b_ovf_i && !trap_ctl_ff[`TIC_OVB_TE_BIT] && !acc_a_ovf_i
     && !acc_a_cat_ovf_i && !acc_b_cat_ovf_i) |=> !acc_trap_o)
    else $error("overflow trap raised while disabled");
  a_cov_trap_raise: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL2]
    (clk_en_i && acc_a_cat_ovf_i && trap_ctl_ff[`TIC_COV_TE_BIT])
    |=> acc_trap_o && trap_ctl_ff[`TIC_COVA_FLAG_BIT])
    else $error("catastrophic overflow trap missed");
  a_div_fault_set: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL3]
    (clk_en_i && arith_trap_i && arith_div0_i) |=> trap_ctl_ff[`TIC_DIV_FAULT_BIT])
    else $error("divide fault not set");
  a_addr_fault_set: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL4]
    (clk_en_i && address_trap_i) |=> trap_ctl_ff[`TIC_ADDR_FAULT_BIT] && irq_stat_ff[3])
    else $error("address fault not set");
  a_stack_fault_set: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL5]
    (clk_en_i && stack_trap_i) |=> trap_ctl_ff[`TIC_STACK_FAULT_BIT])
    else $error("stack fault not set");
  a_clk_fail_set: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL6]
    (clk_en_i && osc_fail_trap_i) |=> trap_ctl_ff[`TIC_CLK_FAIL_BIT])
    else $error("clock failure flag not set");
  a_unimpl_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL7]
    trap_ctl_ff[5] == 1'b0 && trap_ctl_ff[0] == 1'b0 && vec_edge_rd[13:3] == 11'h000)
    else $error("unimplemented bit set");
  a_vec_select: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL8]
    (wr_take && avs_address_i == `TIC_OFF_VEC_EDGE && avs_byteenable_i[1])
    |=> vector_table_select_o == $past(avs_writedata_i[15]))
    else $error("vector select not taken");
  a_edge_rise: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL9]
    (clk_en_i && !vec_edge_ff[0] && $rose(g_edge[0].u_edge.sync_ff)) |-> ext_irq_req_o[0])
    else $error("rising edge missed");
  a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL11]
    (trap_ctl_ff[`TIC_STACK_FAULT_BIT] && !wr_take) |=> trap_ctl_ff[`TIC_STACK_FAULT_BIT])
    else $error("flag cleared without write");
  // enabled accumulator a overflow traps and logs its flag
  a_ova_trap_raise: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL1]
    (clk_en_i && acc_a_ovf_i && trap_ctl_ff[`TIC_OVA_TE_BIT])
    |=> acc_trap_o && trap_ctl_ff[`TIC_OVA_FLAG_BIT])
    else $error("overflow trap missed");
  // disabled catastrophic overflow raises no trap
  a_cov_trap_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL2]
    (clk_en_i && acc_b_cat_ovf_i && !trap_ctl_ff[`TIC_COV_TE_BIT] && !acc_a_cat_ovf_i
     && !acc_a_ovf_i && !acc_b_ovf_i) |=> !acc_trap_o)
    else $error("catastrophic overflow trap raised while disabled");
  // divide fault stays clear without a divide-by-zero trap
  a_div_fault_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL3]
    (clk_en_i && !trap_ctl_ff[`TIC_DIV_FAULT_BIT] && !(arith_trap_i && arith_div0_i)
     && !(wr_take && avs_address_i == `TIC_OFF_TRAP_CTL))
    |=> !trap_ctl_ff[`TIC_DIV_FAULT_BIT])
    else $error("divide fault set without cause");
  // address fault stays clear without an address trap
  a_addr_fault_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL4]
    (clk_en_i && !trap_ctl_ff[`TIC_ADDR_FAULT_BIT] && !address_trap_i
     && !(wr_take && avs_address_i == `TIC_OFF_TRAP_CTL))
    |=> !trap_ctl_ff[`TIC_ADDR_FAULT_BIT])
    else $error("address fault set without cause");
  // a falling edge requests input 0 when its polarity bit is set
  a_edge_fall: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RL9]
    (clk_en_i && vec_edge_ff[0] && $fell(g_edge[0].u_edge.sync_ff)) |-> ext_irq_req_o[0])
    else $error("falling edge missed");
  // an edge event stays in the status until written one
  a_stat_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (irq_stat_ff[0] && !(wr_take && avs_address_i == `TIC_OFF_IRQ_STAT)) |=> irq_stat_ff[0])
    else $error("status bit cleared without write");
endmodule // tic_trap_ctl
`default_nettype wire

// ### verification/tic_core_model.sv
// stand-in for the cpu core trap sources and the three external interrupt pins
// assumes one bench process calls its tasks, all timed by sys_clk_i
`timescale 1ns/10ps
`default_nettype none
module tic_core_model (
  input wire logic sys_clk_i,
  output logic [8:0] ev_o, // trap event pulses, one bit a source
  output logic div0_o, // qualifies the arithmetic pulse
  output logic idis_o, // disable-instruction count running
  output logic [2:0] pin_o // external interrupt pins
);
  // ----------------------------------------
  // idle levels and drivers
  // ----------------------------------------
  // all quiet at time zero so no edge is seen out of reset
  initial begin
    ev_o = 9'h000;
    div0_o = 1'b0;
    idis_o = 1'b0;
    pin_o = 3'h0;
  end
  // one-cycle pulse launched just after an edge, as the core does
  task fire(input int idx, input logic dz);
    @(posedge sys_clk_i);
    ev_o[idx] <= 1'b1;
    div0_o <= dz;
    @(posedge sys_clk_i);
    ev_o <= 9'h000;
    div0_o <= 1'b0;
  endtask
  // pins and disable level move only after an edge
  task levels(input logic [2:0] p, input logic d);
    @(posedge sys_clk_i);
    pin_o <= p;
    idis_o <= d;
  endtask
endmodule // tic_core_model
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench of the trap and interrupt control over avalon-mm
// assumes the design files and tic_core_model are compiled first
`include "tic_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1; // held for four cycles
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [8:0] ev;
  logic dz, idis, acc_trap_o, vector_table_select_o, nest_disable_o, irq_o;
  logic clk_en = 1'b1; // low freezes the design
  logic [2:0] pin, ext_irq_req_o;
  logic [2:0] seen = 3'h0; // edge requests gathered since last clear
  int n_trap = 0; // accumulator trap pulses seen
  int n_mismatch = 0;
  int n_checks = 0;
  tic_pkg::tic_word_t q;
  // overflow cases: enable word, source, pulses expected
  tic_pkg::tic_word_t en_t[7] = '{16'h0000, 16'h0200, 16'h0400, 16'h0200, 16'h0100,
                                   16'h0100, 16'h0000};
  int src_t[7] = '{1, 1, 0, 0, 2, 3, 3};
  int cnt_t[7] = '{0, 1, 1, 0, 1, 1, 0};
  // flag cases: source, divide qualifier, flag word expected
  int fsrc_t[6] = '{4, 5, 5, 6, 7, 8};
  logic fdz_t[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  tic_pkg::tic_word_t fexp_t[6] = '{16'h0080, 16'h0050, 16'h0010, 16'h0008, 16'h0004,
                                     16'h0002};
  tic_pkg::tic_word_t pol_t[3] = '{16'h0000, 16'h0005, 16'h0002};
  // ----------------------------------------
  // instances, clock, monitors
  // ----------------------------------------
  // byteenable tied: every register access uses both low lanes
  tic_trap_ctl dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h3),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .acc_a_ovf_i(ev[0]), .acc_b_ovf_i(ev[1]), .acc_a_cat_ovf_i(ev[2]),
    .acc_b_cat_ovf_i(ev[3]), .shift_acc_fault_i(ev[4]), .arith_trap_i(ev[5]),
    .arith_div0_i(dz), .address_trap_i(ev[6]), .stack_trap_i(ev[7]),
    .osc_fail_trap_i(ev[8]), .irq_disable_instr_active_i(idis), .ext_irq_pin_i(pin),
    .acc_trap_o(acc_trap_o), .vector_table_select_o(vector_table_select_o),
    .nest_disable_o(nest_disable_o), .ext_irq_req_o(ext_irq_req_o), .irq_o(irq_o));
  tic_core_model core (.sys_clk_i(sys_clk_i), .ev_o(ev), .div0_o(dz), .idis_o(idis),
    .pin_o(pin));
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // sampled on the falling edge, where outputs have settled
  always @(negedge sys_clk_i) begin
    if (acc_trap_o === 1'b1) n_trap++;
    seen <= seen | ext_irq_req_o;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // one avalon cycle: hold until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input tic_pkg::tic_word_t d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= {16'h0000, d};
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[15:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task chk(input tic_pkg::tic_word_t g, input tic_pkg::tic_word_t e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input tic_pkg::tic_word_t d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [3:0] a, input tic_pkg::tic_word_t e);
    bus(1'b0, a, 16'h0000);
    chk(q, e);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(`TIC_OFF_TRAP_CTL, 16'h0000);
    rd(`TIC_OFF_VEC_EDGE, 16'h0000);
    rd(`TIC_OFF_IRQ_MASK, 16'h0000);
    chk(vector_table_select_o, 16'h0000);
    $display("test reset values done");
    wr(`TIC_OFF_TRAP_CTL, 16'hFFFF);
    rd(`TIC_OFF_TRAP_CTL, 16'hFFDE);
    chk(nest_disable_o, 16'h0001);
    wr(`TIC_OFF_VEC_EDGE, 16'hFFFF);
    rd(`TIC_OFF_VEC_EDGE, 16'h8007);
    chk(vector_table_select_o, 16'h0001);
    wr(`TIC_OFF_TRAP_CTL, 16'h0000);
    wr(`TIC_OFF_VEC_EDGE, 16'h0000);
    rd(`TIC_OFF_TRAP_CTL, 16'h0000);
    chk(vector_table_select_o, 16'h0000);
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h0000);
    $display("test write masks done");
    // enable word decides whether an overflow becomes a trap
    for (int i = 0; i < 7; i++) begin
      wr(`TIC_OFF_TRAP_CTL, en_t[i]);
      n_trap = 0;
      core.fire(src_t[i], 1'b0);
      repeat (4) @(posedge sys_clk_i);
      chk(n_trap, cnt_t[i]);
    end
    $display("test overflow enables done");
    for (int i = 0; i < 6; i++) begin
      wr(`TIC_OFF_TRAP_CTL, 16'h0000);
      core.fire(fsrc_t[i], fdz_t[i]);
      repeat (4) @(posedge sys_clk_i);
      rd(`TIC_OFF_TRAP_CTL, fexp_t[i]);
      repeat (8) @(posedge sys_clk_i);
      rd(`TIC_OFF_TRAP_CTL, fexp_t[i]);
    end
    wr(`TIC_OFF_TRAP_CTL, 16'h0000);
    rd(`TIC_OFF_TRAP_CTL, 16'h0000);
    $display("test trap flags done");
    // rising then falling edge on each pin under three polarity settings
    wr(`TIC_OFF_IRQ_STAT, 16'hFFFF);
    for (int p = 0; p < 3; p++) begin
      wr(`TIC_OFF_VEC_EDGE, pol_t[p]);
      for (int i = 0; i < 3; i++) begin
        seen <= 3'h0;
        core.levels(3'h1 << i, 1'b0);
        repeat (6) @(posedge sys_clk_i);
        chk(seen, pol_t[p][i] ? 16'h0000 : 16'h0001 << i);
        core.levels(3'h0, 1'b0);
        repeat (6) @(posedge sys_clk_i);
        chk(seen, 16'h0001 << i);
      end
    end
    $display("test edge polarity done");
    rd(`TIC_OFF_IRQ_STAT, 16'h0007);
    chk(irq_o, 16'h0000);
    wr(`TIC_OFF_IRQ_MASK, 16'h0002);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 16'h0001);
    wr(`TIC_OFF_IRQ_STAT, 16'h0002);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 16'h0000);
    rd(`TIC_OFF_IRQ_STAT, 16'h0005);
    $display("test interrupt done");
    // a frozen block loses a trap pulse and keeps its flags
    wr(`TIC_OFF_TRAP_CTL, 16'h0000);
    clk_en <= 1'b0;
    core.fire(7, 1'b0);
    @(posedge sys_clk_i);
    clk_en <= 1'b1;
    rd(`TIC_OFF_TRAP_CTL, 16'h0000);
    $display("test clock enable done");
    // disable status follows the core level and ignores writes
    core.levels(3'h0, 1'b1);
    repeat (4) @(posedge sys_clk_i);
    rd(`TIC_OFF_VEC_EDGE, 16'h4002);
    wr(`TIC_OFF_VEC_EDGE, 16'h0000);
    rd(`TIC_OFF_VEC_EDGE, 16'h4000);
    core.levels(3'h0, 1'b0);
    repeat (4) @(posedge sys_clk_i);
    rd(`TIC_OFF_VEC_EDGE, 16'h0000);
    $display("test disable status done");
    conclude();
  end
  // far longer than the tests need, so only a hang reaches it
  initial begin
    #200000;
    n_mismatch++;
    $display("watchdog expired");
    conclude();
  end
endmodule // testbench
`default_nettype wire
